// >>> ssne_exec.sv
/*
 * Execution datapath for the skip-if-nonzero, subtract and nibble-exchange
 * operations; holds the accumulator and the subtract flags.
 * Assumes the sequencer presents the memory byte already read on mem_rdata
 * with op_valid, on the same clock, and performs any memory write it sees.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssne_params.svh"

module ssne_exec
    import ssne_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  wire ssne_op_e    op,
    input  wire ssne_byte_t  mem_rdata,
    input  wire ssne_byte_t  imm,
    input  wire logic        acc_wr_en,
    input  wire ssne_byte_t  acc_wr_data,
    output logic             ready_ff,
    output logic             done_ff,
    output logic             skip_ff,
    output logic             dummy_ff,
    output logic             mem_we_ff,
    output ssne_byte_t       mem_wdata_ff,
    output ssne_byte_t       acc_ff,
    output ssne_flags_s      flags_ff
);

    // ------------------------------------------------------------------
    // State and next values
    // ------------------------------------------------------------------
    typedef enum logic {SSNE_IDLE, SSNE_DUMMY} ssne_state_e;

    ssne_state_e   state_ff;
    ssne_state_e   nxt_state;
    logic          nxt_ready;
    logic          nxt_done;
    logic          nxt_skip;
    logic          nxt_dummy;
    logic          nxt_mem_we;
    ssne_byte_t    nxt_mem_wdata;
    ssne_byte_t    nxt_acc;
    ssne_flags_s   nxt_flags;
    ssne_byte_t    sub_b;
    ssne_sub_res_s sub_res;
    logic          accept;

    assign accept = op_valid && (state_ff == SSNE_IDLE);
    assign sub_b  = (op == SSNE_OP_SUB_IMM) ? imm : mem_rdata;

    ssne_sub u_sub (
        .minuend    (acc_ff),
        .subtrahend (sub_b),
        .res        (sub_res)
    );

    always_comb begin
        nxt_state     = state_ff;
        nxt_done      = 1'b0;
        nxt_skip      = 1'b0;
        nxt_dummy     = 1'b0;
        nxt_mem_we    = 1'b0;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_acc       = acc_wr_en ? acc_wr_data : acc_ff;
        nxt_flags     = flags_ff;
        case (state_ff)
            SSNE_IDLE: begin
                if (accept) begin
                    case (op)
                        SSNE_OP_SKIP_IF_NONZERO: begin
                            // Skip decision now; dummy cycle follows.
                            nxt_skip  = (mem_rdata != `SSNE_BYTE_ZERO);
                            nxt_dummy = 1'b1;
                            nxt_state = SSNE_DUMMY;
                        end
                        SSNE_OP_SUB_MEM: begin
                            nxt_acc   = sub_res.diff;
                            nxt_flags = sub_res.flags;
                            nxt_done  = 1'b1;
                        end
                        SSNE_OP_DIFFERENCE_TO_MEMORY: begin
                            nxt_mem_we    = 1'b1;
                            nxt_mem_wdata = sub_res.diff;
                            nxt_flags     = sub_res.flags;
                            nxt_done      = 1'b1;
                        end
                        SSNE_OP_SUB_IMM: begin
                            nxt_acc   = sub_res.diff;
                            nxt_flags = sub_res.flags;
                            nxt_done  = 1'b1;
                        end
                        SSNE_OP_NIBBLE_EXCHANGE: begin
                            nxt_mem_we    = 1'b1;
                            nxt_mem_wdata = ssne_swap_nibbles(mem_rdata);
                            nxt_done      = 1'b1;
                        end
                        SSNE_OP_NIBBLE_EXCHANGE_TO_ACC: begin
                            nxt_acc  = ssne_swap_nibbles(mem_rdata);
                            nxt_done = 1'b1;
                        end
                        default: begin
                            nxt_done = 1'b1;
                        end
                    endcase
                end
            end
            SSNE_DUMMY: begin
                // The fetched instruction is discarded here when skipping.
                nxt_skip  = skip_ff;
                nxt_done  = 1'b1;
                nxt_state = SSNE_IDLE;
            end
            default: begin
                nxt_state = SSNE_IDLE;
            end
        endcase
        nxt_ready = (nxt_state == SSNE_IDLE);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= SSNE_IDLE;
            ready_ff     <= 1'b1;
            done_ff      <= 1'b0;
            skip_ff      <= 1'b0;
            dummy_ff     <= 1'b0;
            mem_we_ff    <= 1'b0;
            mem_wdata_ff <= `SSNE_BYTE_ZERO;
            acc_ff       <= `SSNE_ACC_RST;
            flags_ff     <= '0;
        end else begin
            state_ff     <= nxt_state;
            ready_ff     <= nxt_ready;
            done_ff      <= nxt_done;
            skip_ff      <= nxt_skip;
            dummy_ff     <= nxt_dummy;
            mem_we_ff    <= nxt_mem_we;
            mem_wdata_ff <= nxt_mem_wdata;
            acc_ff       <= nxt_acc;
            flags_ff     <= nxt_flags;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Independent reference for the immediate form, not taken from u_sub.
    ssne_byte_t chk_imm_diff;
    logic       chk_sub_op;
    assign chk_imm_diff = acc_ff - imm;
    assign chk_sub_op   = (op == SSNE_OP_SUB_MEM) || (op == SSNE_OP_SUB_IMM)
                       || (op == SSNE_OP_DIFFERENCE_TO_MEMORY);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_skip_go;
        accept && op == SSNE_OP_SKIP_IF_NONZERO;
    endsequence
    sequence s_dummy_then_done;
        dummy_ff && !done_ff && !ready_ff ##1 done_ff && ready_ff;
    endsequence

    property p_skip_nonzero;
        s_skip_go |=> skip_ff == ($past(mem_rdata) != `SSNE_BYTE_ZERO)
                      && flags_ff == $past(flags_ff);
    endproperty
    a_skip_nonzero: assert property (p_skip_nonzero)
        else $error("skip decision or flags wrong");

    property p_skip_two_cycles;
        s_skip_go |=> s_dummy_then_done;
    endproperty
    a_skip_two_cycles: assert property (p_skip_two_cycles)
        else $error("skip op did not take two cycles");

    property p_sub_mem;
        accept && op == SSNE_OP_SUB_MEM && !acc_wr_en
            |=> acc_ff == $past(acc_ff) - $past(mem_rdata)
                && done_ff && !mem_we_ff;
    endproperty
    a_sub_mem: assert property (p_sub_mem)
        else $error("subtract memory result wrong");

    property p_diff_to_mem;
        accept && op == SSNE_OP_DIFFERENCE_TO_MEMORY && !acc_wr_en
            |=> mem_we_ff
                && mem_wdata_ff == $past(acc_ff) - $past(mem_rdata)
                && acc_ff == $past(acc_ff)
                ##1 (!mem_we_ff || $past(accept));
    endproperty
    a_diff_to_mem: assert property (p_diff_to_mem)
        else $error("difference to memory wrong");

    property p_sub_imm;
        accept && op == SSNE_OP_SUB_IMM && !acc_wr_en
            |=> acc_ff == $past(chk_imm_diff);
    endproperty
    a_sub_imm: assert property (p_sub_imm)
        else $error("subtract immediate result wrong");

    property p_borrow;
        accept && op == SSNE_OP_SUB_IMM
            |=> flags_ff.borrow_inverse_flag == ($past(acc_ff) >= $past(imm));
    endproperty
    a_borrow: assert property (p_borrow)
        else $error("borrow inverse flag wrong");

    property p_flags_only_on_sub;
        !(accept && chk_sub_op) |=> flags_ff == $past(flags_ff);
    endproperty
    a_flags_only_on_sub: assert property (p_flags_only_on_sub)
        else $error("flags changed by a non-subtract op");

    property p_swap_mem;
        accept && op == SSNE_OP_NIBBLE_EXCHANGE
            |=> mem_we_ff
                && mem_wdata_ff[`SSNE_MSB:`SSNE_NIB_HI_BOT]
                   == $past(mem_rdata[`SSNE_NIB_LO_TOP:0])
                && mem_wdata_ff[`SSNE_NIB_LO_TOP:0]
                   == $past(mem_rdata[`SSNE_MSB:`SSNE_NIB_HI_BOT]);
    endproperty
    a_swap_mem: assert property (p_swap_mem)
        else $error("nibble exchange in place wrong");

    property p_swap_acc;
        accept && op == SSNE_OP_NIBBLE_EXCHANGE_TO_ACC && !acc_wr_en
            |=> acc_ff == {$past(mem_rdata[`SSNE_NIB_LO_TOP:0]),
                           $past(mem_rdata[`SSNE_MSB:`SSNE_NIB_HI_BOT])}
                && !mem_we_ff;
    endproperty
    a_swap_acc: assert property (p_swap_acc)
        else $error("nibble exchange to accumulator wrong");

    property p_zero_wrap;
        accept && op == SSNE_OP_SUB_IMM
            |=> flags_ff.zero_flag == ($past(acc_ff) == $past(imm))
                && flags_ff.twos_complement_wrap_flag
                   == (($past(acc_ff[`SSNE_MSB]) != $past(imm[`SSNE_MSB]))
                       && (acc_ff[`SSNE_MSB] != $past(acc_ff[`SSNE_MSB])));
    endproperty
    a_zero_wrap: assert property (p_zero_wrap)
        else $error("zero or wrap flag wrong");

endmodule : ssne_exec

`default_nettype wire

// >>> ssne_params.svh
/*
 * Constants for the skip, subtract and nibble-exchange execution datapath.
 * Assumes it is included by bare name from the package, ssne_exec and ssne_sub.
 */
`ifndef SSNE_PARAMS_SVH
`define SSNE_PARAMS_SVH

`define SSNE_DATA_W      8
`define SSNE_MSB         7
`define SSNE_NIB_LO_TOP  3
`define SSNE_NIB_HI_BOT  4
`define SSNE_NIB_W       5
`define SSNE_ACC_RST     8'h00
`define SSNE_BYTE_ZERO   8'h00
`define SSNE_SKIP_CYCLES 2

`endif

// >>> ssne_pkg.sv
/*
 * Types shared by the execution datapath and its subtract unit.
 * Assumes ssne_params.svh sits in the same folder.
 */
`include "ssne_params.svh"

package ssne_pkg;

    // ------------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SSNE_OP_SKIP_IF_NONZERO,
        SSNE_OP_SUB_MEM,
        SSNE_OP_DIFFERENCE_TO_MEMORY,
        SSNE_OP_SUB_IMM,
        SSNE_OP_NIBBLE_EXCHANGE,
        SSNE_OP_NIBBLE_EXCHANGE_TO_ACC
    } ssne_op_e;

    typedef logic [`SSNE_DATA_W-1:0] ssne_byte_t;

    // ------------------------------------------------------------------
    // Flags touched by the subtract forms
    // ------------------------------------------------------------------
    typedef struct packed {
        logic twos_complement_wrap_flag;
        logic zero_flag;
        logic nibble_carry_flag;
        logic borrow_inverse_flag;
        logic signed_compare_flag;
        logic chained_result_null_flag;
    } ssne_flags_s;

    typedef struct packed {
        ssne_byte_t  diff;
        ssne_flags_s flags;
    } ssne_sub_res_s;

    function automatic ssne_byte_t ssne_swap_nibbles(input ssne_byte_t b);
        return {b[`SSNE_NIB_LO_TOP:0], b[`SSNE_MSB:`SSNE_NIB_HI_BOT]};
    endfunction : ssne_swap_nibbles

endpackage : ssne_pkg

// >>> ssne_sub.sv
/*
 * Combinational 8-bit subtractor producing the difference and its flags.
 * Assumes operands are stable within the cycle in which they are used.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssne_params.svh"

module ssne_sub
    import ssne_pkg::*;
(
    input  wire ssne_byte_t    minuend,
    input  wire ssne_byte_t    subtrahend,
    output var  ssne_sub_res_s res
);

    logic [`SSNE_DATA_W:0]  full;
    logic [`SSNE_NIB_W-1:0] low;
    logic                   wrap;

    always_comb begin
        full = {1'b0, minuend} - {1'b0, subtrahend};
        low  = {1'b0, minuend[`SSNE_NIB_LO_TOP:0]}
             - {1'b0, subtrahend[`SSNE_NIB_LO_TOP:0]};
        // Signed wrap: operands differ in sign and result sign follows b.
        wrap = (minuend[`SSNE_MSB] ^ subtrahend[`SSNE_MSB])
             & (full[`SSNE_MSB] ^ minuend[`SSNE_MSB]);
        res.diff                           = full[`SSNE_DATA_W-1:0];
        res.flags.twos_complement_wrap_flag = wrap;
        res.flags.zero_flag = (full[`SSNE_DATA_W-1:0] == `SSNE_BYTE_ZERO);
        res.flags.nibble_carry_flag   = ~low[`SSNE_NIB_W-1];
        res.flags.borrow_inverse_flag = ~full[`SSNE_DATA_W];
        res.flags.signed_compare_flag = wrap ^ full[`SSNE_MSB];
        // Without a borrow chain the chained zero equals the plain zero.
        res.flags.chained_result_null_flag =
            (full[`SSNE_DATA_W-1:0] == `SSNE_BYTE_ZERO);
    end

endmodule : ssne_sub

`default_nettype wire

// >>> ssne_mem_model.sv
/*
 * Behavioural data memory standing behind the execution datapath.
 * Assumes one clock; the bench preloads bytes through the load port.
 */
`timescale 1ns/1ps
`default_nettype none

module ssne_mem_model
    import ssne_pkg::*;
(
    input  wire logic       clock,
    input  wire logic [3:0] addr,
    input  wire logic       sel,
    input  wire logic       ld_en,
    input  wire ssne_byte_t ld_data,
    input  wire logic       we,
    input  wire ssne_byte_t wdata,
    output var  ssne_byte_t rdata
);
    ssne_byte_t mem [16];

    // An unselected read shows the inverted byte, so stale data never
    // passes for a fresh operand.
    assign rdata = sel ? mem[addr] : ~mem[addr];

    always @(posedge clock) begin
        if (ld_en) begin
            mem[addr] <= ld_data;
        end else if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule : ssne_mem_model

`default_nettype wire

// >>> ssne_exec_tb_top.sv
/*
 * Self-checking bench for the execution datapath: a table of single
 * operations, then skip, refusal, override and back-to-back cases.
 * Assumes ssne_mem_model stands in for the data memory at address 0.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    bad_count++; $display("ERROR %0t got %h exp %h", $time, got, exp); end end

module ssne_exec_tb_top import ssne_pkg::*; ();
    typedef struct {
        ssne_op_e   op;
        ssne_byte_t a, m, i, exp_acc, exp_mem;
    } ssne_row_s;

    logic        clock = 1'b0, rst_n = 1'b0, peek = 1'b0;
    logic        op_valid = 1'b0, acc_wr_en = 1'b0, ld_en = 1'b0;
    ssne_op_e    op = SSNE_OP_SUB_MEM;
    ssne_byte_t  imm = 8'h00, acc_wr_data = 8'h00, ld_data = 8'h00;
    logic        ready_ff, done_ff, skip_ff, dummy_ff, mem_we_ff;
    ssne_byte_t  mem_rdata, mem_wdata_ff, acc_ff;
    ssne_flags_s flags_ff, exp_f = '0;
    int          bad_count = 0, cmp_count = 0;
    ssne_byte_t  skv [3] = '{8'h01, 8'h00, 8'h80};
    ssne_row_s   rows [9] = '{
        '{SSNE_OP_SUB_MEM, 8'h08, 8'h05, 8'h00, 8'h03, 8'h05},
        '{SSNE_OP_SUB_MEM, 8'h05, 8'h08, 8'h00, 8'hfd, 8'h08},
        '{SSNE_OP_SUB_MEM, 8'h80, 8'h01, 8'h00, 8'h7f, 8'h01},
        '{SSNE_OP_DIFFERENCE_TO_MEMORY, 8'h10, 8'h10, 8'h00, 8'h10, 8'h00},
        '{SSNE_OP_DIFFERENCE_TO_MEMORY, 8'h02, 8'h03, 8'h00, 8'h02, 8'hff},
        '{SSNE_OP_SUB_IMM, 8'h7f, 8'h00, 8'hff, 8'h80, 8'h00},
        '{SSNE_OP_SUB_IMM, 8'h33, 8'h44, 8'h03, 8'h30, 8'h44},
        '{SSNE_OP_NIBBLE_EXCHANGE, 8'h11, 8'ha5, 8'h00, 8'h11, 8'h5a},
        '{SSNE_OP_NIBBLE_EXCHANGE_TO_ACC, 8'h00, 8'h3c, 8'h00, 8'hc3, 8'h3c}
    };

    always #2 clock = ~clock;

    ssne_exec ssne_exec_inst (
        .clock(clock), .rst_n(rst_n), .op_valid(op_valid), .op(op),
        .mem_rdata(mem_rdata), .imm(imm), .acc_wr_en(acc_wr_en),
        .acc_wr_data(acc_wr_data), .ready_ff(ready_ff), .done_ff(done_ff),
        .skip_ff(skip_ff), .dummy_ff(dummy_ff), .mem_we_ff(mem_we_ff),
        .mem_wdata_ff(mem_wdata_ff), .acc_ff(acc_ff), .flags_ff(flags_ff));

    ssne_mem_model ssne_mem_model_inst (
        .clock(clock), .addr(4'h0), .sel(op_valid | peek), .ld_en(ld_en),
        .ld_data(ld_data), .we(mem_we_ff), .wdata(mem_wdata_ff),
        .rdata(mem_rdata));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic ssne_flags_s flg(input ssne_byte_t a, input ssne_byte_t b);
        ssne_byte_t d;
        logic       v;
        d = a - b;
        v = (a[7] != b[7]) && (d[7] != a[7]);
        return '{v, d == 8'h00, a[3:0] >= b[3:0], a >= b, v ^ d[7], d == 8'h00};
    endfunction : flg

    task automatic step();
        @(posedge clock);
        #1;
    endtask : step

    task automatic load(input ssne_byte_t a, input ssne_byte_t m);
        acc_wr_en = 1'b1;
        acc_wr_data = a;
        ld_en = 1'b1;
        ld_data = m;
        step();
        acc_wr_en = 1'b0;
        ld_en = 1'b0;
    endtask : load

    task automatic report_and_stop();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        #(4 * 1000);
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        `CHK({ready_ff, done_ff, skip_ff, dummy_ff, acc_ff, flags_ff}, 18'h20000)
        foreach (rows[k]) begin
            load(rows[k].a, rows[k].m);
            op_valid = 1'b1;
            op = rows[k].op;
            imm = rows[k].i;
            step();
            op_valid = 1'b0;
            peek = 1'b1;
            if (op inside {SSNE_OP_SUB_MEM, SSNE_OP_DIFFERENCE_TO_MEMORY}) begin
                exp_f = flg(rows[k].a, rows[k].m);
            end else if (op == SSNE_OP_SUB_IMM) begin
                exp_f = flg(rows[k].a, rows[k].i);
            end
            `CHK(acc_ff, rows[k].exp_acc)
            `CHK(flags_ff, exp_f)
            `CHK({done_ff, mem_we_ff}, {1'b1, op inside
                {SSNE_OP_DIFFERENCE_TO_MEMORY, SSNE_OP_NIBBLE_EXCHANGE}})
            step();
            `CHK({done_ff, mem_rdata}, {1'b0, rows[k].exp_mem})
            peek = 1'b0;
        end
        // The subtract held through the dummy cycle must wait for ready.
        foreach (skv[k]) begin
            load(8'h05, skv[k]);
            op_valid = 1'b1;
            op = SSNE_OP_SKIP_IF_NONZERO;
            step();
            op = SSNE_OP_SUB_IMM;
            imm = 8'h01;
            `CHK({skip_ff, dummy_ff, ready_ff, done_ff}, {skv[k] != 8'h00, 3'b100})
            step();
            `CHK({skip_ff, dummy_ff, done_ff, acc_ff, flags_ff},
                {skv[k] != 8'h00, 2'b01, 8'h05, exp_f})
            step();
            exp_f = flg(8'h05, 8'h01);
            `CHK({done_ff, skip_ff, acc_ff, flags_ff}, {2'b10, 8'h04, exp_f})
            op_valid = 1'b0;
        end
        // Back to back with an accumulator load that the op must override.
        load(8'h09, 8'h00);
        step();
        acc_wr_en = 1'b1;
        acc_wr_data = 8'hff;
        op_valid = 1'b1;
        op = SSNE_OP_SUB_IMM;
        imm = 8'h02;
        step();
        acc_wr_en = 1'b0;
        imm = 8'h03;
        `CHK(acc_ff, 8'h07)
        step();
        op_valid = 1'b0;
        `CHK({done_ff, acc_ff, flags_ff}, {1'b1, 8'h04, flg(8'h07, 8'h03)})
        // An accumulator load lands when the accepted op leaves it alone.
        step();
        acc_wr_en = 1'b1;
        acc_wr_data = 8'h5c;
        op_valid = 1'b1;
        op = SSNE_OP_DIFFERENCE_TO_MEMORY;
        step();
        acc_wr_en = 1'b0;
        op = ssne_op_e'(3'h7);
        `CHK({done_ff, mem_we_ff, mem_wdata_ff, acc_ff, flags_ff},
            {2'b11, 8'h04, 8'h5c, flg(8'h04, 8'h00)})
        // An unused op code completes with no effect on any state.
        step();
        op_valid = 1'b0;
        `CHK({done_ff, mem_we_ff, acc_ff, flags_ff},
            {2'b10, 8'h5c, flg(8'h04, 8'h00)})
        // A reset in mid-run clears the accumulator and the flags.
        rst_n = 1'b0;
        step();
        `CHK({ready_ff, done_ff, mem_we_ff, mem_wdata_ff, acc_ff, flags_ff},
            {3'b100, 8'h00, 8'h00, 6'h00})
        rst_n = 1'b1;
        report_and_stop();
    end
endmodule : ssne_exec_tb_top

`default_nettype wire
